// [verilog/rsgl_top.sv]
// Module: general pin logic of a multi-rail power sequencer
//
// Contract
// - Output is OR of two AND terms
// - Terms use logic outputs, inputs, rail flags
// - One status type per gate, rail subset
// - Sticky flags clear by command or pin
// - Many rail status types, all also sticky
// - Delay on assert, deassert, both, none
// - Normal delay filters reverting glitches
// - Ignore mode commits change after delay
// - Ignore mode pulses last at least delay
// - State machine mode picks one path
// - One pin per special input function
// - Timeout source deassertion is a fault
// - Clear-source pin clears sticky flags
// - Margin enable puts enabled rails margined
// - Low/not-high pin picks margin direction
// - Input polarity configurable per pin
// - First three inputs feed rail-state select
// - Rail enable pin polarity and drive mode
// - In reset pins float, fast pins low
// - At most twelve rail-enable pins
// - Cascade via power-good to host control
// - Pins driven by command or logic
`timescale 1ns/100ps
module rsgl_top (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // General pins
  input wire logic [rsgl_pkg::N_PIN-1:0] PIN_IN,
  output logic [rsgl_pkg::N_PIN-1:0] PIN_OUT,
  output logic [rsgl_pkg::N_PIN-1:0] PIN_OE,
  // Sequencer side
  input wire logic [rsgl_pkg::N_STAT-1:0][rsgl_pkg::N_RAIL-1:0] RAIL_STAT,
  input wire logic [rsgl_pkg::N_RAIL-1:0] RAIL_EN_REQ,
  input wire logic HOST_CONTROL_INPUT,
  output logic SEQ_RUN,
  output logic SEQ_TIMEOUT_FAULT,
  output logic [rsgl_pkg::N_RAIL-1:0] MARGIN_EN_RAIL,
  output logic [rsgl_pkg::N_RAIL-1:0] MARGIN_LOW_RAIL,
  output logic [rsgl_pkg::N_SEL-1:0] RAIL_STATE_SEL
);
  import rsgl_pkg::*;

  // --------------------------------------------------------------
  // Configuration storage
  // --------------------------------------------------------------
  rsgl_term_t tsel_r [N_LO][2];
  logic [N_RAIL-1:0] trail_r [N_LO][2];
  rsgl_ocfg_t ocfg_r [N_LO];
  rsgl_pin_t pin_r [N_PIN];
  rsgl_gpi_t gpi_r [N_GPI];
  rsgl_func_t func_r [N_FUNC];
  logic [N_RAIL-1:0] mrg_mask_r;
  logic [N_STAT-1:0][N_RAIL-1:0] lat_r;
  logic [N_GPI-1:0] gpi_q_r;
  logic fault_r;
  logic [5:0] tick_cnt_r;
  logic tick_r;
  logic [N_LO-1:0] lo_vec;

  // --------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------
  wire [2:0] lo_idx = REG_ADDR[5:3];
  wire [2:0] fld = REG_ADDR[2:0];
  wire [4:0] pin_idx = REG_ADDR[4:0];
  wire [2:0] gpi_idx = REG_ADDR[2:0];
  wire [1:0] fn_idx = REG_ADDR[1:0];
  wire hit_lo = (REG_ADDR[7:6] == 2'h0) && (fld <= F_OCFG);
  wire hit_pin = (REG_ADDR[7:5] == A_PIN[7:5]) && (pin_idx < N_PIN);
  wire hit_gpi = (REG_ADDR[7:3] == A_GPI[7:3]);
  wire hit_fn = (REG_ADDR[7:2] == A_FUNC[7:2]);
  wire wr_lo = REG_WR && hit_lo;
  wire wr_pin = REG_WR && hit_pin;
  wire wr_gpi = REG_WR && hit_gpi;
  wire wr_fn = REG_WR && hit_fn;
  wire wr_mrg = REG_WR && (REG_ADDR == A_MRG_MASK);
  wire wr_cmd = REG_WR && (REG_ADDR == A_CMD);

  // --------------------------------------------------------------
  // Rail-enable pin budget
  // --------------------------------------------------------------
  function automatic logic [4:0] rail_pins(input rsgl_pin_t p [N_PIN]);
    logic [4:0] n;
    n = 5'h00;
    for (int k = 0; k < N_PIN; k++) begin
      n = n + 5'(p[k].src == SRC_RAIL);
    end
    return n;
  endfunction

  wire rsgl_pin_t pin_w = rsgl_pin_t'(REG_WDATA[12:0]);
  wire [4:0] rail_cnt = rail_pins(pin_r);
  // A write that would add a thirteenth enable pin is dropped whole
  wire pin_reject = (pin_w.src == SRC_RAIL) &&
    (pin_r[pin_idx].src != SRC_RAIL) && (rail_cnt >= 5'(MAX_RAIL_EN));

  // --------------------------------------------------------------
  // Input pins: polarity and special functions
  // --------------------------------------------------------------
  logic [N_GPI-1:0] gpi_v;
  for (genvar k = 0; k < N_GPI; k++) begin : g_gpi
    // Logical level of a defined input, after polarity
    assign gpi_v[k] = gpi_r[k].def &&
      (PIN_IN[gpi_r[k].pin] ^ gpi_r[k].act_low);
  end

  // Each function holds a single slot, so a second pin cannot be bound
  logic [N_FUNC-1:0] fn_v;
  logic [N_FUNC-1:0] fn_q;
  for (genvar f = 0; f < N_FUNC; f++) begin : g_fn
    assign fn_v[f] = func_r[f].en && gpi_v[func_r[f].slot];
    assign fn_q[f] = func_r[f].en && gpi_q_r[func_r[f].slot];
  end
  wire seq_to_evt = fn_q[FN_SEQ_TO] && !fn_v[FN_SEQ_TO];
  wire lat_clr = (fn_v[FN_LAT_CLR] && !fn_q[FN_LAT_CLR]) ||
    (wr_cmd && REG_WDATA[CMD_CLR_LAT]);
  wire fault_clr = wr_cmd && REG_WDATA[CMD_CLR_FAULT];

  // First three defined inputs, in slot order
  function automatic logic [N_SEL-1:0] pick_sel(
    input rsgl_gpi_t g [N_GPI], input logic [N_GPI-1:0] v);
    logic [N_SEL-1:0] r;
    logic [1:0] n;
    r = '0;
    n = 2'h0;
    for (int k = 0; k < N_GPI; k++) begin
      if (g[k].def && (n < 2'(N_SEL))) begin
        r[n] = v[k];
        n = n + 2'h1;
      end
    end
    return r;
  endfunction
  wire [N_SEL-1:0] sel_w = pick_sel(gpi_r, gpi_v);

  // --------------------------------------------------------------
  // AND term evaluation
  // --------------------------------------------------------------
  function automatic logic term_eval(
    input rsgl_term_t t, input logic [N_RAIL-1:0] rm,
    input logic [N_GPI-1:0] gv, input logic [N_LO-1:0] lv,
    input logic [N_STAT-1:0][N_RAIL-1:0] raw,
    input logic [N_STAT-1:0][N_RAIL-1:0] lat);
    logic [N_RAIL-1:0] fl;
    logic any;
    fl = '0;
    // One status type per gate, plain or sticky copy
    if (t.stype < 5'(N_STAT)) begin
      fl = t.latched ? lat[t.stype] : raw[t.stype];
    end
    // An empty term never counts as true
    any = (|t.gmask) || (|t.lmask) || (|rm);
    return any && (&(gv | ~t.gmask)) &&
      (&(lv | ~t.lmask)) && (&(fl | ~rm));
  endfunction

  // --------------------------------------------------------------
  // Delay time base
  // --------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt_r <= 6'h00;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == 6'(TICK_CYC - 1));
      tick_cnt_r <= (tick_cnt_r == 6'(TICK_CYC - 1)) ? 6'h00 :
        tick_cnt_r + 6'h01;
    end
  end

  // --------------------------------------------------------------
  // Logic outputs: Boolean block plus delay machine
  // --------------------------------------------------------------
  for (genvar i = 0; i < N_LO; i++) begin : g_lo
    rsgl_dst_t st_r;
    rsgl_dst_t st_nxt;
    logic lo_r;
    logic lo_nxt;
    logic tgt_r;
    logic tgt_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    rsgl_ocfg_t oc;
    logic t0;
    logic t1;
    logic raw;
    logic chg;
    logic dly_to_raw;
    logic done;
    assign oc = ocfg_r[i];
    assign t0 = term_eval(tsel_r[i][0], trail_r[i][0], gpi_v, lo_vec,
      RAIL_STAT, lat_r);
    assign t1 = term_eval(tsel_r[i][1], trail_r[i][1], gpi_v, lo_vec,
      RAIL_STAT, lat_r);
    // State machine mode looks at a single path at a time
    assign raw = oc.sm ? (lo_r ? t0 : t1) : (t0 || t1);
    assign chg = (raw != lo_r);
    assign dly_to_raw = (raw ? oc.dly_up : oc.dly_dn) &&
      (oc.ticks != 16'h0000);
    assign done = tick_r && (cnt_r >= oc.ticks); // Full delay, never short
    assign lo_vec[i] = lo_r;

    // After a commit in ignore mode, an undelayed return edge would
    // make a short pulse, so the new level is held for the delay
    function automatic logic need_hold(input logic v, input rsgl_ocfg_t c);
      return c.ign && (c.ticks != 16'h0000) &&
        !(v ? c.dly_dn : c.dly_up);
    endfunction

    // Next state of the delay machine
    always_comb begin
      st_nxt = st_r;
      lo_nxt = lo_r;
      tgt_nxt = tgt_r;
      cnt_nxt = tick_r ? cnt_r + 16'h0001 : cnt_r;
      unique case (st_r)
        RSGL_IDLE: begin
          cnt_nxt = 16'h0000;
          if (chg && dly_to_raw) begin
            st_nxt = RSGL_WAIT;
            tgt_nxt = raw;
          end else if (chg) begin
            lo_nxt = raw;
            st_nxt = need_hold(raw, oc) ? RSGL_HOLD : RSGL_IDLE;
          end
        end
        RSGL_WAIT: begin
          if (!oc.ign && !chg) begin
            st_nxt = RSGL_IDLE;
          end else if (done) begin
            lo_nxt = tgt_r;
            cnt_nxt = 16'h0000;
            st_nxt = need_hold(tgt_r, oc) ? RSGL_HOLD : RSGL_IDLE;
          end
        end
        RSGL_HOLD: begin
          if (done) begin
            st_nxt = RSGL_IDLE;
          end
        end
        default: begin
          st_nxt = RSGL_IDLE;
        end
      endcase
    end

    // Delay machine registers
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        st_r <= RSGL_IDLE;
        lo_r <= 1'b0;
        tgt_r <= 1'b0;
        cnt_r <= 16'h0000;
      end else begin
        st_r <= st_nxt;
        lo_r <= lo_nxt;
        tgt_r <= tgt_nxt;
        cnt_r <= cnt_nxt;
      end
    end

    // Term and delay setup writes
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        tsel_r[i] <= '{default: '0};
        trail_r[i] <= '{default: '0};
        ocfg_r[i] <= '0;
      end else if (wr_lo && (lo_idx == 3'(i))) begin
        if (fld == F_T0_SEL) tsel_r[i][0] <= REG_WDATA[21:0];
        if (fld == F_T0_RAIL) trail_r[i][0] <= REG_WDATA[N_RAIL-1:0];
        if (fld == F_T1_SEL) tsel_r[i][1] <= REG_WDATA[21:0];
        if (fld == F_T1_RAIL) trail_r[i][1] <= REG_WDATA[N_RAIL-1:0];
        if (fld == F_OCFG) ocfg_r[i] <= REG_WDATA[19:0];
      end
    end
  end

  // --------------------------------------------------------------
  // General pins: source, polarity, drive
  // --------------------------------------------------------------
  for (genvar p = 0; p < N_PIN; p++) begin : g_pin
    localparam rsgl_pin_t RST = (p >= FAST_LO && p <= FAST_HI) ?
      PIN_RST_FAST : PIN_RST;
    logic val;
    logic lvl;
    // Manual value from command, Boolean block, or rail enable
    assign val = (pin_r[p].src == SRC_LOGIC) ? lo_vec[pin_r[p].lsel] :
      (pin_r[p].src == SRC_RAIL) ?
        ((pin_r[p].rail < 4'(N_RAIL)) && RAIL_EN_REQ[pin_r[p].rail]) :
      pin_r[p].man;
    assign lvl = val ^ pin_r[p].act_low;

    // Pin setup register
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        pin_r[p] <= RST;
      end else if (wr_pin && (pin_idx == 5'(p)) && !pin_reject) begin
        pin_r[p] <= pin_w;
      end
    end

    // Fast pins drive low in reset; others float
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        PIN_OUT[p] <= 1'b0;
        PIN_OE[p] <= RST.drive;
      end else begin
        PIN_OUT[p] <= !pin_r[p].od && lvl;
        PIN_OE[p] <= pin_r[p].drive && (!pin_r[p].od || !lvl);
      end
    end
  end

  // --------------------------------------------------------------
  // Input and function setup
  // --------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gpi_r <= '{default: '0};
      func_r <= '{default: '0};
      mrg_mask_r <= '0;
    end else begin
      if (wr_gpi) gpi_r[gpi_idx] <= REG_WDATA[6:0];
      if (wr_fn) func_r[fn_idx] <= REG_WDATA[3:0];
      if (wr_mrg) mrg_mask_r <= REG_WDATA[N_RAIL-1:0];
    end
  end

  // --------------------------------------------------------------
  // Sticky flags, fault and side outputs
  // --------------------------------------------------------------
  // A flag raised in the clearing cycle survives the clear
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lat_r <= '0;
      gpi_q_r <= '0;
      fault_r <= 1'b0;
    end else begin
      lat_r <= (lat_clr ? '0 : lat_r) | RAIL_STAT;
      gpi_q_r <= gpi_v;
      fault_r <= seq_to_evt || (fault_r && !fault_clr);
    end
  end

  // Flopped side outputs toward the sequencer
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SEQ_RUN <= 1'b0;
      SEQ_TIMEOUT_FAULT <= 1'b0;
      MARGIN_EN_RAIL <= '0;
      MARGIN_LOW_RAIL <= '0;
      RAIL_STATE_SEL <= '0;
    end else begin
      SEQ_RUN <= HOST_CONTROL_INPUT;
      SEQ_TIMEOUT_FAULT <= seq_to_evt;
      MARGIN_EN_RAIL <= fn_v[FN_MRG_EN] ? mrg_mask_r : '0;
      MARGIN_LOW_RAIL <= (fn_v[FN_MRG_EN] && fn_v[FN_MRG_LOW]) ?
        mrg_mask_r : '0;
      RAIL_STATE_SEL <= sel_w;
    end
  end

  // --------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------
  wire [31:0] rd_lo = (fld == F_T0_SEL) ? 32'(tsel_r[lo_idx][0]) :
    (fld == F_T0_RAIL) ? 32'(trail_r[lo_idx][0]) :
    (fld == F_T1_SEL) ? 32'(tsel_r[lo_idx][1]) :
    (fld == F_T1_RAIL) ? 32'(trail_r[lo_idx][1]) :
    32'(ocfg_r[lo_idx]);
  wire [31:0] rd_stat = {13'h0000, rail_cnt, lo_vec, sel_w,
    fn_v[FN_MRG_LOW], fn_v[FN_MRG_EN], fault_r};
  wire [31:0] rd_mux = hit_lo ? rd_lo :
    hit_pin ? 32'(pin_r[pin_idx]) :
    hit_gpi ? 32'(gpi_r[gpi_idx]) :
    hit_fn ? 32'(func_r[fn_idx]) :
    (REG_ADDR == A_MRG_MASK) ? 32'(mrg_mask_r) :
    (REG_ADDR == A_STATUS) ? rd_stat : 32'h0000_0000;

  // Read data stands for exactly one cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 32'h0000_0000;
    end else begin
      REG_RDATA <= REG_RD ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

// [verilog/rsgl_pkg.sv]
// Package: constants and types for the rail sequencer pin logic
package rsgl_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int N_PIN = 22;
  localparam int N_GPI = 8;
  localparam int N_LO = 8;
  localparam int N_RAIL = 12;
  localparam int N_STAT = 18;
  localparam int N_FUNC = 4;
  localparam int N_SEL = 3;
  localparam int MAX_RAIL_EN = 12;
  localparam int FAST_LO = 4;
  localparam int FAST_HI = 11;
  // ----------------------------------------------------------------
  // Time base for output delays
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // ----------------------------------------------------------------
  // Register word indices
  // ----------------------------------------------------------------
  localparam logic [7:0] A_PIN = 8'h40;
  localparam logic [7:0] A_GPI = 8'h60;
  localparam logic [7:0] A_FUNC = 8'h68;
  localparam logic [7:0] A_MRG_MASK = 8'h6c;
  localparam logic [7:0] A_CMD = 8'h6d;
  localparam logic [7:0] A_STATUS = 8'h6e;
  localparam logic [2:0] F_T0_SEL = 3'h0;
  localparam logic [2:0] F_T0_RAIL = 3'h1;
  localparam logic [2:0] F_T1_SEL = 3'h2;
  localparam logic [2:0] F_T1_RAIL = 3'h3;
  localparam logic [2:0] F_OCFG = 3'h4;
  localparam int CMD_CLR_LAT = 0;
  localparam int CMD_CLR_FAULT = 1;
  // Special input functions
  localparam int FN_SEQ_TO = 0;
  localparam int FN_LAT_CLR = 1;
  localparam int FN_MRG_EN = 2;
  localparam int FN_MRG_LOW = 3;
  // Pin output sources
  localparam logic [1:0] SRC_MANUAL = 2'h0;
  localparam logic [1:0] SRC_LOGIC = 2'h1;
  localparam logic [1:0] SRC_RAIL = 2'h2;
  // Rail status type codes
  localparam logic [4:0] ST_POWER_GOOD = 5'h00;
  localparam logic [4:0] ST_MARGIN_EN = 5'h01;
  localparam logic [4:0] ST_MARGIN_LOW = 5'h02;
  localparam logic [4:0] ST_OV_FAULT = 5'h03;
  localparam logic [4:0] ST_OV_WARN = 5'h04;
  localparam logic [4:0] ST_UV_WARN = 5'h05;
  localparam logic [4:0] ST_UV_FAULT = 5'h06;
  localparam logic [4:0] ST_TON_FAULT = 5'h07;
  localparam logic [4:0] ST_TOFF_WARN = 5'h08;
  localparam logic [4:0] ST_OC_FAULT = 5'h09;
  localparam logic [4:0] ST_OC_WARN = 5'h0a;
  localparam logic [4:0] ST_UC_FAULT = 5'h0b;
  localparam logic [4:0] ST_OT_FAULT = 5'h0c;
  localparam logic [4:0] ST_OT_WARN = 5'h0d;
  localparam logic [4:0] ST_SEQ_UP_TO = 5'h0e;
  localparam logic [4:0] ST_SEQ_DOWN_TO = 5'h0f;
  localparam logic [4:0] ST_WDOG_TO = 5'h10;
  localparam logic [4:0] ST_SEQ_TO = 5'h11;
  // ----------------------------------------------------------------
  // Configuration words
  // ----------------------------------------------------------------
  typedef struct packed {
    logic latched;
    logic [4:0] stype;
    logic [N_LO-1:0] lmask;
    logic [N_GPI-1:0] gmask;
  } rsgl_term_t;
  typedef struct packed {
    logic sm;
    logic ign;
    logic dly_dn;
    logic dly_up;
    logic [15:0] ticks;
  } rsgl_ocfg_t;
  typedef struct packed {
    logic od;
    logic act_low;
    logic [3:0] rail;
    logic [2:0] lsel;
    logic man;
    logic [1:0] src;
    logic drive;
  } rsgl_pin_t;
  typedef struct packed {
    logic def;
    logic act_low;
    logic [4:0] pin;
  } rsgl_gpi_t;
  typedef struct packed {
    logic en;
    logic [2:0] slot;
  } rsgl_func_t;
  typedef enum logic [1:0] {
    RSGL_IDLE = 2'b00,
    RSGL_WAIT = 2'b01,
    RSGL_HOLD = 2'b10
  } rsgl_dst_t;
  localparam rsgl_pin_t PIN_RST = 13'h0000;
  localparam rsgl_pin_t PIN_RST_FAST = 13'h0001;
endpackage

// [test/rsgl_partner.sv]
// Far-side model: pin wires with pull-downs and a cascade master
`timescale 1ns/100ps
module rsgl_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin side
  input wire logic [rsgl_pkg::N_PIN-1:0] pin_out,
  input wire logic [rsgl_pkg::N_PIN-1:0] pin_oe,
  input wire logic [rsgl_pkg::N_PIN-1:0] ext_val,
  input wire logic [rsgl_pkg::N_PIN-1:0] ext_oe,
  output logic [rsgl_pkg::N_PIN-1:0] pin_wire,
  // Cascade master
  input wire logic master_on,
  output logic host_ctl
);
  import rsgl_pkg::*;
  logic [2:0] cnt_r;
  // Undriven pins fall to the pull-down that holds supplies off
  assign pin_wire = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val);
  // Master rails reach regulation some cycles after start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 3'h0;
    else if (!master_on) cnt_r <= 3'h0;
    else if (cnt_r != 3'h6) cnt_r <= cnt_r + 3'h1;
  end
  // Shutdown reaches the slave at once, no delay
  assign host_ctl = master_on && cnt_r == 3'h6;
endmodule

// [test/rsgl_top_assertions.sv]
// Port checker for the rail sequencer pin logic
`timescale 1ns/100ps
module rsgl_top_assertions (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  // Pins and sequencer side
  input wire logic [rsgl_pkg::N_PIN-1:0] PIN_IN,
  input wire logic [rsgl_pkg::N_PIN-1:0] PIN_OUT,
  input wire logic [rsgl_pkg::N_PIN-1:0] PIN_OE,
  input wire logic HOST_CONTROL_INPUT,
  input wire logic SEQ_RUN,
  input wire logic SEQ_TIMEOUT_FAULT,
  input wire logic [rsgl_pkg::N_RAIL-1:0] MARGIN_EN_RAIL,
  input wire logic [rsgl_pkg::N_RAIL-1:0] MARGIN_LOW_RAIL,
  input wire logic [rsgl_pkg::N_SEL-1:0] RAIL_STATE_SEL
);
  import rsgl_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  logic wr_seen_r;
  // Marks the first write since reset
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) wr_seen_r <= 1'b0;
    else if (REG_WR) wr_seen_r <= 1'b1;
  end
  // No write and no input change: nothing to react to
  sequence quiet_s;
    !REG_WR && $stable(PIN_IN);
  endsequence
  reset_exit_a: assert property ($past(ARST_N) == 1'b0 |->
    PIN_OE == 22'h000ff0 && PIN_OUT == '0 && SEQ_RUN == 1'b0)
    else $error("Pins not in reset state after release");
  fast_hold_a: assert property (!wr_seen_r |->
    PIN_OE == 22'h000ff0 && PIN_OUT == '0)
    else $error("Pin drive changed before any setup");
  seq_follow_a: assert property ($past(ARST_N) |->
    SEQ_RUN == $past(HOST_CONTROL_INPUT))
    else $error("Run flag does not follow host control");
  rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == '0)
    else $error("Read data outside the read answer cycle");
  fault_pulse_a: assert property (SEQ_TIMEOUT_FAULT |=> !SEQ_TIMEOUT_FAULT)
    else $error("Timeout fault longer than one cycle");
  margin_dir_a: assert property ((MARGIN_LOW_RAIL & ~MARGIN_EN_RAIL) == '0)
    else $error("Margin low on a rail not margined");
  sel_quiet_a: assert property (quiet_s [*3] |=> $stable(RAIL_STATE_SEL))
    else $error("Rail state select moved without cause");
  margin_quiet_a: assert property (quiet_s [*3] |=>
    $stable(MARGIN_EN_RAIL) && $stable(MARGIN_LOW_RAIL))
    else $error("Margin outputs moved without cause");
endmodule
bind rsgl_top rsgl_top_assertions chk (.CORE_CLK, .ARST_N, .REG_WR, .REG_RD,
  .REG_RDATA, .PIN_IN, .PIN_OUT, .PIN_OE, .HOST_CONTROL_INPUT, .SEQ_RUN,
  .SEQ_TIMEOUT_FAULT, .MARGIN_EN_RAIL, .MARGIN_LOW_RAIL, .RAIL_STATE_SEL);

// [test/testbench.sv]
// Self-checking bench for the rail sequencer pin logic
`timescale 1ns/100ps
module testbench;
  import rsgl_pkg::*;
  logic clk, rst_n, wr, rd, hci, m_on, srun, sto;
  logic [7:0] addr;
  logic [31:0] wdat, rdat, d, lf = 32'hf92a;
  logic [N_PIN-1:0] pout, poe, pin, ev, eo;
  logic [N_STAT-1:0][N_RAIL-1:0] st;
  logic [N_RAIL-1:0] req, men, mlo, pg, ovf;
  logic [N_SEL-1:0] sel;
  logic [167:0] nz = '0;
  logic [31:0] expq[$];
  int miscompares, checks_done, cyc, n, k;
  assign st = {nz, ovf, 24'h0, pg};
  rsgl_top uut (.CORE_CLK(clk), .ARST_N(rst_n), .REG_ADDR(addr),
    .REG_WDATA(wdat), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
    .PIN_IN(pin), .PIN_OUT(pout), .PIN_OE(poe), .RAIL_STAT(st),
    .RAIL_EN_REQ(req), .HOST_CONTROL_INPUT(hci), .SEQ_RUN(srun),
    .SEQ_TIMEOUT_FAULT(sto), .MARGIN_EN_RAIL(men),
    .MARGIN_LOW_RAIL(mlo), .RAIL_STATE_SEL(sel));
  rsgl_partner far (.clk(clk), .rst_n(rst_n), .pin_out(pout),
    .pin_oe(poe), .ext_val(ev), .ext_oe(eo), .pin_wire(pin),
    .master_on(m_on), .host_ctl(hci));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdat <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic pset(input int i, input logic v);
    @(posedge clk);
    ev[i] <= v;
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Clock, noise on unused status types, and a hang limit
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    lf <= lfsr(lf);
    nz <= {6{lf[27:0]}};
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      finish_test;
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 0; wr = 0; rd = 0; addr = 0; wdat = 0; ev = 0; eo = 22'h7;
    pg = 0; ovf = 0; req = 0; m_on = 0;
    miscompares = 0; checks_done = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("oe", poe, 22'h000ff0);
    chk("out", pout, 0);
    for (n = 0; n < 4; n++) begin
      expq.push_back(lf & 32'hfff);
      wreg(8'h39, lf & 32'hfff);
      rreg(8'h39);
      chk("rails", d, expq.pop_front());
    end
    wreg(8'h7f, 32'hffffffff);
    rreg(8'h7f);
    chk("unmapped", d, 0);
    wreg(8'h60, 32'h40); wreg(8'h61, 32'h41); wreg(8'h62, 32'h42);
    wreg(8'h00, 32'h1); wreg(8'h02, 32'h0); wreg(8'h03, 32'h8);
    wreg(8'h45, 32'h3);
    pset(0, 1); wt(3);
    chk("p5", pout[5], 1);
    chk("sel", sel, 3'b001);
    pset(0, 0); @(posedge clk) pg[3] <= 1'b1; wt(3);
    chk("p5", pout[5], 1);
    @(posedge clk) pg[3] <= 1'b0; wreg(8'h60, 32'h60); wt(3);
    chk("p5", pout[5], 1);
    chk("sel", sel, 3'b001);
    wreg(8'h60, 32'h40); wreg(8'h02, 32'h230000);
    @(posedge clk) ovf[3] <= 1'b1; @(posedge clk) ovf[3] <= 1'b0; wt(4);
    chk("p5", pout[5], 1);
    wreg(8'h6d, 32'h1); wt(3);
    chk("p5", pout[5], 0);
    @(posedge clk) ovf[3] <= 1'b1; @(posedge clk) ovf[3] <= 1'b0;
    wreg(8'h69, 32'h9); pset(1, 1); wt(4);
    chk("p5", pout[5], 0);
    wreg(8'h68, 32'h9); pset(1, 0); k = 0;
    repeat (6) begin
      @(posedge clk);
      #1 if (sto === 1'b1) k++;
    end
    chk("fault", k, 1);
    rreg(8'h6e);
    chk("status", d[0], 1);
    wreg(8'h6d, 32'h2); wreg(8'h68, 32'ha); pset(1, 1); pset(1, 0); wt(4);
    rreg(8'h6e);
    chk("status", d[0], 0);
    wreg(8'h6c, 32'hf); wreg(8'h6a, 32'h8); wreg(8'h6b, 32'ha);
    pset(0, 1); pset(2, 1); wt(3);
    chk("men", men, 12'h00f);
    chk("mlo", mlo, 12'h00f);
    pset(2, 0); wt(3);
    chk("mlo", mlo, 0);
    pset(0, 0); wt(3);
    chk("men", men, 0);
    wreg(8'h02, 32'h0); wreg(8'h04, 32'h30002);
    pset(0, 1); wt(30); pset(0, 0); k = 0;
    repeat (200) begin
      @(posedge clk);
      #1 if (pout[5] === 1'b1) k++;
    end
    chk("glitch", k, 0);
    pset(0, 1); wt(60);
    chk("p5", pout[5], 0);
    wt(70);
    chk("p5", pout[5], 1);
    pset(0, 0); wt(130);
    chk("p5", pout[5], 0);
    wreg(8'h04, 32'h70002); pset(0, 1); wt(10); pset(0, 0); k = 0;
    repeat (300) begin
      @(posedge clk);
      #1 if (pout[5] === 1'b1) k++;
    end
    chk("pulse", k >= 80, 1);
    wreg(8'h04, 32'h50002); pset(0, 1); wt(10); pset(0, 0); k = 0;
    repeat (300) begin
      @(posedge clk);
      #1 if (pout[5] === 1'b1) k++;
    end
    chk("hold", k >= 80, 1);
    wreg(8'h04, 32'h80000); wreg(8'h02, 32'h2); wreg(8'h03, 32'h0);
    pset(0, 1); wt(3);
    chk("p5", pout[5], 0);
    pset(1, 1); wt(3); pset(1, 0); wt(3);
    chk("p5", pout[5], 1);
    @(posedge clk) m_on <= 1'b1; wt(10);
    chk("run", srun, 1);
    @(posedge clk) m_on <= 1'b0; wt(2);
    chk("run", srun, 0);
    // Pin 13 is not fast, so an active-low enable is allowed there
    wreg(8'h4d, 32'h1805); @(posedge clk) req[0] <= 1'b1; wt(3);
    chk("oe13", poe[13], 1);
    chk("out13", pout[13], 0);
    @(posedge clk) req[0] <= 1'b0; wt(3);
    chk("oe13", poe[13], 0);
    for (n = 1; n < 22; n++)
      if (n < 4 || n > 13) wreg(8'h40 + n[7:0], 32'h4);
    wreg(8'h44, 32'h4);
    rreg(8'h44);
    chk("pin4", d, 32'h1);
    rreg(8'h6e);
    chk("count", d[18:14], 5'h0c);
    finish_test;
  end
endmodule
